// ### logic/shp_defs.svh
// Constants shared by both ends of the serial host port.
`ifndef SHP_DEFS_SVH
`define SHP_DEFS_SVH
`define SHP_CLK_PERIOD_NS 100
`define SHP_MAX_RATE_KBPS 10000
`define SHP_SCK_PERIOD_NS 800
`define SHP_MIN_SCK_PERIOD_NS (1000000 / `SHP_MAX_RATE_KBPS)
`define SHP_SCK_HALF_CYC ((`SHP_SCK_PERIOD_NS / 2) / `SHP_CLK_PERIOD_NS)
`define SHP_NSS_HIGH_NS 50
`define SHP_NSS_HIGH_CYC ((`SHP_NSS_HIGH_NS + `SHP_CLK_PERIOD_NS - 1) / `SHP_CLK_PERIOD_NS)
`define SHP_FIFO_ADDR 7'h05
`define SHP_DUMMY_BYTE 8'h00
`define SHP_STRAP_WAIT 2'h2
`endif

// ### logic/shp_dev.sv
// Device end of the serial host port: strap decode, SPI slave and register access requests.
// Functional notes
// RULE_01: Reset port, read select straps at wake.
// RULE_02: Straps pick UART, SPI, I2C or I2CL.
// RULE_03: Device is slave; master drives SCK, MOSI.
// RULE_04: Link rate at most 10 Mbit/s.
// RULE_05: Select high disables and resets the port.
// RULE_06: Master raises select between commands.
// RULE_07: Bytes travel most significant bit first.
// RULE_08: Master changes MOSI only after falling edge.
// RULE_09: Device changes MISO on falling SCK edge.
// RULE_10: SCK idles low.
// RULE_11: First byte: address above, bit0 read flag.
// RULE_12: Read data returns during the next byte.
// RULE_13: Write data lands at rising addresses.
// RULE_14: FIFO address never auto-increments; host read bursts still step past it, one address per byte.
// RULE_15: Select stays low through one stream.
// RULE_16: Master ignores MISO when undefined.
// RULE_17: Each byte becomes one-cycle bank request; the address byte of a write stream makes none.
`include "shp_defs.svh"
module shp_dev (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Link.
    shp_if.dev link,
    // Interface select straps and wake.
    input wire logic host_sel_pin_lo_i,
    input wire logic host_sel_pin_hi_i,
    input wire logic wake_i,
    output shp_pkg::shp_host_if_t host_if_mode_o,
    output logic host_if_valid_o,
    // Register bank access.
    output logic req_valid_o,
    output logic req_write_o,
    output logic [6:0] req_addr_o,
    output logic [7:0] req_wdata_o,
    input wire logic [7:0] rd_data_i
);
    import shp_pkg::*;

    function automatic shp_host_if_t shp_decode_sel(input logic hi, input logic lo);
        case ({hi, lo})
            2'b00: shp_decode_sel = SHP_IF_UART;
            2'b10: shp_decode_sel = SHP_IF_SPI;
            2'b01: shp_decode_sel = SHP_IF_I2C;
            default: shp_decode_sel = SHP_IF_I2CL;
        endcase
    endfunction

    // Two-stage synchronisers; the third sck stage only serves edge detection.
    logic sck_s1, sck_s2, sck_s3;
    logic mosi_s1, mosi_s2;
    logic ss_s1, ss_s2;
    logic sel_lo_s1, sel_lo_s2, sel_hi_s1, sel_hi_s2;
    logic wake_s1, wake_s2;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
            ss_s1 <= 1'b1;
            ss_s2 <= 1'b1;
            sel_lo_s1 <= 1'b0;
            sel_lo_s2 <= 1'b0;
            sel_hi_s1 <= 1'b0;
            sel_hi_s2 <= 1'b0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            sck_s1 <= link.sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            mosi_s1 <= link.mosi;
            mosi_s2 <= mosi_s1;
            ss_s1 <= link.slave_select_n;
            ss_s2 <= ss_s1;
            sel_lo_s1 <= host_sel_pin_lo_i;
            sel_lo_s2 <= sel_lo_s1;
            sel_hi_s1 <= host_sel_pin_hi_i;
            sel_hi_s2 <= sel_hi_s1;
            wake_s1 <= wake_i;
            wake_s2 <= wake_s1;
        end
    end

    logic sck_rise, sck_fall;
    assign sck_rise = sck_s2 & ~sck_s3;
    assign sck_fall = ~sck_s2 & sck_s3;

    // Strap capture group: a few cycles after reset release or wake the straps are latched.
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic strap_done_r, strap_done_nxt;
    shp_host_if_t mode_r, mode_nxt;

    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        strap_done_nxt = strap_done_r;
        mode_nxt = mode_r;
        if (wake_s2) begin
            strap_cnt_nxt = 2'h0; // [RULE_01]
            strap_done_nxt = 1'b0;
        end else if (!strap_done_r) begin
            if (strap_cnt_r == `SHP_STRAP_WAIT) begin
                mode_nxt = shp_decode_sel(sel_hi_s2, sel_lo_s2); // [RULE_01] [RULE_02]
                strap_done_nxt = 1'b1;
            end else begin
                strap_cnt_nxt = strap_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            mode_r <= SHP_IF_UART;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            strap_done_r <= strap_done_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign host_if_mode_o = mode_r;
    assign host_if_valid_o = strap_done_r;

    // Serial engine group.
    logic spi_en;
    assign spi_en = strap_done_r && (mode_r == SHP_IF_SPI) && !ss_s2; // [RULE_05]

    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic first_r, first_nxt;
    logic rd_mode_r, rd_mode_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic cap_r, cap_nxt;
    logic load_pend_r, load_pend_nxt;
    logic miso_r, miso_nxt;
    logic req_valid_r, req_valid_nxt;
    logic req_write_r, req_write_nxt;
    logic [6:0] req_addr_r, req_addr_nxt;
    logic [7:0] req_wdata_r, req_wdata_nxt;
    logic [7:0] rx_byte;

    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        rx_sh_nxt = rx_sh_r;
        first_nxt = first_r;
        rd_mode_nxt = rd_mode_r;
        addr_nxt = addr_r;
        tx_sh_nxt = tx_sh_r;
        hold_nxt = hold_r;
        cap_nxt = 1'b0;
        load_pend_nxt = load_pend_r;
        miso_nxt = miso_r;
        req_valid_nxt = 1'b0;
        req_write_nxt = req_write_r;
        req_addr_nxt = req_addr_r;
        req_wdata_nxt = req_wdata_r;
        rx_byte = {rx_sh_r[6:0], mosi_s2}; // [RULE_07]
        if (cap_r) begin
            hold_nxt = rd_data_i;
            load_pend_nxt = 1'b1;
        end
        if (!spi_en) begin
            bit_cnt_nxt = 3'h0; // [RULE_05]
            first_nxt = 1'b1;
            load_pend_nxt = 1'b0;
            tx_sh_nxt = 8'h00;
            miso_nxt = 1'b0;
        end else if (sck_rise) begin
            rx_sh_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
                if (first_r) begin
                    first_nxt = 1'b0;
                    rd_mode_nxt = rx_byte[0]; // [RULE_11]
                    addr_nxt = rx_byte[7:1];
                end
                if (first_r ? rx_byte[0] : rd_mode_r) begin
                    req_valid_nxt = 1'b1; // [RULE_12] [RULE_17]
                    req_write_nxt = 1'b0;
                    req_addr_nxt = rx_byte[7:1];
                    cap_nxt = 1'b1;
                end else if (!first_r) begin
                    req_valid_nxt = 1'b1; // [RULE_13] [RULE_17]
                    req_write_nxt = 1'b1;
                    req_addr_nxt = addr_r;
                    req_wdata_nxt = rx_byte;
                    if (addr_r != `SHP_FIFO_ADDR) begin // [RULE_14]
                        addr_nxt = addr_r + 7'h01; // [RULE_13]
                    end
                end
            end
        end else if (sck_fall) begin
            if (load_pend_r) begin
                miso_nxt = hold_r[7]; // [RULE_09] [RULE_12]
                tx_sh_nxt = {hold_r[6:0], 1'b0};
                load_pend_nxt = 1'b0;
            end else begin
                miso_nxt = tx_sh_r[7]; // [RULE_09] [RULE_07]
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
            first_r <= 1'b1;
            rd_mode_r <= 1'b0;
            addr_r <= 7'h00;
            tx_sh_r <= 8'h00;
            hold_r <= 8'h00;
            cap_r <= 1'b0;
            load_pend_r <= 1'b0;
            miso_r <= 1'b0;
            req_valid_r <= 1'b0;
            req_write_r <= 1'b0;
            req_addr_r <= 7'h00;
            req_wdata_r <= 8'h00;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            first_r <= first_nxt;
            rd_mode_r <= rd_mode_nxt;
            addr_r <= addr_nxt;
            tx_sh_r <= tx_sh_nxt;
            hold_r <= hold_nxt;
            cap_r <= cap_nxt;
            load_pend_r <= load_pend_nxt;
            miso_r <= miso_nxt;
            req_valid_r <= req_valid_nxt;
            req_write_r <= req_write_nxt;
            req_addr_r <= req_addr_nxt;
            req_wdata_r <= req_wdata_nxt;
        end
    end

    assign link.miso = miso_r; // [RULE_03]
    assign req_valid_o = req_valid_r;
    assign req_write_o = req_write_r;
    assign req_addr_o = req_addr_r;
    assign req_wdata_o = req_wdata_r;
endmodule

// ### logic/shp_host.sv
// Host end of the serial host port: SPI master issuing register bursts.
`include "shp_defs.svh"
module shp_host (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Link.
    shp_if.host link,
    // Command.
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_read_i,
    input wire logic [6:0] cmd_addr_i,
    input wire logic [3:0] cmd_len_i,
    // Write data.
    input wire logic [7:0] wr_data_i,
    output logic wr_take_o,
    // Read data.
    output logic [7:0] rd_data_o,
    output logic rd_valid_o
);
    import shp_pkg::*;

    localparam logic [2:0] HALF_M1 = 3'(`SHP_SCK_HALF_CYC - 1);
    localparam logic [2:0] GAP_M1 = 3'(`SHP_SCK_HALF_CYC - 1);

    logic miso_s1, miso_s2;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= link.miso;
            miso_s2 <= miso_s1;
        end
    end

    shp_host_st_t st_r, st_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [4:0] byte_r, byte_nxt;
    logic [4:0] nbytes_r, nbytes_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic read_r, read_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic sck_r, sck_nxt;
    logic ss_n_r, ss_n_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic wr_take_r, wr_take_nxt;
    logic [7:0] rx_byte;
    logic [4:0] byte_inc;

    assign cmd_ready_o = (st_r == SHP_H_IDLE);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        nbytes_nxt = nbytes_r;
        addr_nxt = addr_r;
        read_nxt = read_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        sck_nxt = sck_r;
        ss_n_nxt = ss_n_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        wr_take_nxt = 1'b0;
        rx_byte = {rx_r[6:0], miso_s2};
        byte_inc = byte_r + 5'h01;
        case (st_r)
            SHP_H_IDLE: begin
                sck_nxt = 1'b0; // [RULE_10]
                ss_n_nxt = 1'b1;
                if (cmd_valid_i && cmd_len_i != 4'h0) begin
                    read_nxt = cmd_read_i;
                    addr_nxt = cmd_addr_i;
                    nbytes_nxt = {1'b0, cmd_len_i} + 5'h01; // [RULE_12] [RULE_13]
                    tx_nxt = {cmd_addr_i, cmd_read_i}; // [RULE_11]
                    byte_nxt = 5'h00;
                    bit_nxt = 3'h0;
                    cnt_nxt = 3'h0;
                    ss_n_nxt = 1'b0; // [RULE_15]
                    st_nxt = SHP_H_LOW;
                end
            end
            SHP_H_LOW: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == HALF_M1) begin
                    cnt_nxt = 3'h0;
                    sck_nxt = 1'b1; // [RULE_04] [RULE_08]
                    st_nxt = SHP_H_HIGH;
                end
            end
            SHP_H_HIGH: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == HALF_M1) begin
                    cnt_nxt = 3'h0;
                    sck_nxt = 1'b0;
                    rx_nxt = rx_byte; // [RULE_07] [RULE_09]
                    bit_nxt = bit_r + 3'h1;
                    tx_nxt = {tx_r[6:0], 1'b0}; // [RULE_08]
                    st_nxt = SHP_H_LOW;
                    if (bit_r == 3'h7) begin
                        byte_nxt = byte_inc;
                        if (read_r && byte_r != 5'h00) begin
                            rd_data_nxt = rx_byte; // [RULE_16] [RULE_12]
                            rd_valid_nxt = 1'b1;
                        end
                        if (!read_r) begin
                            tx_nxt = wr_data_i;
                            wr_take_nxt = 1'b1;
                        end else if (byte_inc + 5'h01 == nbytes_r) begin
                            tx_nxt = `SHP_DUMMY_BYTE; // [RULE_12]
                        end else begin
                            tx_nxt = {addr_r + 7'(byte_inc), 1'b1};
                        end
                        if (byte_inc == nbytes_r) begin
                            wr_take_nxt = 1'b0;
                            st_nxt = SHP_H_GAP;
                        end
                    end
                end
            end
            SHP_H_GAP: begin
                ss_n_nxt = 1'b1; // [RULE_06]
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == GAP_M1) begin
                    cnt_nxt = 3'h0;
                    st_nxt = SHP_H_IDLE;
                end
            end
            default: begin
                st_nxt = SHP_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= SHP_H_IDLE;
            cnt_r <= 3'h0;
            bit_r <= 3'h0;
            byte_r <= 5'h00;
            nbytes_r <= 5'h00;
            addr_r <= 7'h00;
            read_r <= 1'b0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            sck_r <= 1'b0;
            ss_n_r <= 1'b1;
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
            wr_take_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            nbytes_r <= nbytes_nxt;
            addr_r <= addr_nxt;
            read_r <= read_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            sck_r <= sck_nxt;
            ss_n_r <= ss_n_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            wr_take_r <= wr_take_nxt;
        end
    end

    assign link.sck = sck_r; // [RULE_03]
    assign link.mosi = tx_r[7]; // [RULE_07]
    assign link.slave_select_n = ss_n_r;
    assign rd_data_o = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign wr_take_o = wr_take_r;
endmodule

// ### logic/shp_if.sv
// Four-wire serial link between the host and the device.
interface shp_if;
    logic sck;
    logic mosi;
    logic miso;
    logic slave_select_n;
    modport dev (input sck, input mosi, input slave_select_n, output miso);
    modport host (output sck, output mosi, output slave_select_n, input miso);
endinterface

// ### logic/shp_pkg.sv
// Types shared by both ends of the serial host port.
package shp_pkg;
    typedef enum logic [1:0] {SHP_IF_UART, SHP_IF_SPI, SHP_IF_I2C, SHP_IF_I2CL} shp_host_if_t;
    typedef enum {SHP_H_IDLE, SHP_H_LOW, SHP_H_HIGH, SHP_H_GAP} shp_host_st_t;
endpackage

// ### test/shp_chk.sv
// Assertions on the link that joins the host end to the device end.
module shp_chk (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Link.
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic slave_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_d_r;
    logic [7:0] rise_cnt_r;
    logic [7:0] rise_cnt_nxt;
    // Counts clock rises inside one select-low frame, so frames can be checked for whole bytes.
    always_comb begin
        rise_cnt_nxt = rise_cnt_r + {7'h00, sck & ~sck_d_r};
        if (slave_select_n) begin
            rise_cnt_nxt = 8'h00;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_d_r <= 1'b0;
            rise_cnt_r <= 8'h00;
        end else begin
            sck_d_r <= sck;
            rise_cnt_r <= rise_cnt_nxt;
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_quiet_lead;
        !sck [*4];
    endsequence
    sequence s_high_half;
        sck [*4];
    endsequence
    sequence s_low_half;
        !sck [*4];
    endsequence
    a_lead_in_clock: assert property ($fell(slave_select_n) |-> s_quiet_lead ##1 sck)
        else $error("clock did not start four cycles after select fell");
    a_high_half: assert property ($rose(sck) |-> s_high_half ##1 !sck)
        else $error("clock high phase not four cycles");
    a_low_half: assert property ($fell(sck) |-> s_low_half)
        else $error("clock low phase shorter than four cycles");
    a_idle_clock_low: assert property (slave_select_n |-> !sck)
        else $error("clock high while link idle");
    a_mosi_steady_high: assert property (sck |-> $stable(mosi))
        else $error("mosi moved while clock high");
    a_miso_after_fall: assert property ($changed(miso) && !slave_select_n |-> !sck && !$past(sck))
        else $error("miso moved outside the clock low phase");
    a_select_gap: assert property ($rose(slave_select_n) |-> slave_select_n [*3])
        else $error("select high gap too short");
    a_whole_bytes: assert property ($rose(slave_select_n) |-> rise_cnt_r[2:0] == 3'h0 && rise_cnt_r != 8'h00)
        else $error("frame ended inside a byte");
endmodule

// ### test/tb_spi_host_register_port.sv
// Bench joining host and device ends over one link; a second device faces a link driven by the bench.
`include "shp_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_spi_host_register_port;
    timeunit 1ns;
    timeprecision 1ns;
    import shp_pkg::*;
    logic ref_clk_i, resetn_i, cmd_valid_i, cmd_read_i, cmd_ready_o, wr_take_o, rd_valid_o;
    logic [6:0] cmd_addr_i, req_addr_o, req_a2, a0;
    logic [3:0] cmd_len_i, n0;
    logic [7:0] wr_data_i, rd_data_o, rd_data_i, req_wdata_o, req_d2, exp_first, sh;
    logic req_valid_o, req_write_o, valid1, req_v2, req_w2, valid2, sel_lo2, sel_hi2, wake2;
    logic frame_rd, sck_p, prev_req;
    shp_host_if_t mode1, mode2;
    shp_host_if_t exp_mode [4] = '{SHP_IF_UART, SHP_IF_I2C, SHP_IF_SPI, SHP_IF_I2CL};
    logic [7:0] bank [128];
    logic [7:0] mmem [128];
    logic [7:0] wbuf [16];
    logic [15:0] e16;
    logic [15:0] exp_req [$];
    logic [15:0] exp_req2 [$];
    logic [7:0] exp_rd [$];
    int mismatches, samples_checked, wk, nbits;
    integer seed = 32'hce03_1506;
    shp_if link1();
    shp_if link2();
    shp_chk shp_chk_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sck(link1.sck), .mosi(link1.mosi),
        .miso(link1.miso), .slave_select_n(link1.slave_select_n));
    shp_host shp_host_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link1), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
        .wr_data_i(wr_data_i), .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
    shp_dev shp_dev_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link1), .host_sel_pin_lo_i(1'b0),
        .host_sel_pin_hi_i(1'b1), .wake_i(1'b0), .host_if_mode_o(mode1), .host_if_valid_o(valid1),
        .req_valid_o(req_valid_o), .req_write_o(req_write_o), .req_addr_o(req_addr_o),
        .req_wdata_o(req_wdata_o), .rd_data_i(rd_data_i));
    shp_dev shp_dev_flt_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link2), .host_sel_pin_lo_i(sel_lo2),
        .host_sel_pin_hi_i(sel_hi2), .wake_i(wake2), .host_if_mode_o(mode2), .host_if_valid_o(valid2),
        .req_valid_o(req_v2), .req_write_o(req_w2), .req_addr_o(req_a2), .req_wdata_o(req_d2),
        .rd_data_i(8'hff));
    assign rd_data_i = bank[req_addr_o];
    assign wr_data_i = wbuf[wk];
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (cmd_valid_i === 1'b1 && cmd_ready_o === 1'b1) begin
            wk <= 0;
        end else if (wr_take_o === 1'b1) begin
            wk <= wk + 1;
        end
        if (req_valid_o === 1'b1 && req_write_o === 1'b1) bank[req_addr_o] <= req_wdata_o;
        if (req_valid_o === 1'b1) begin
            `CHK("req_pulse", 1'b0, prev_req)
            e16 = exp_req.size() ? exp_req.pop_front() : 16'hffff;
            `CHK("req", e16, {req_write_o, req_addr_o, req_write_o ? req_wdata_o : 8'h00})
        end
        prev_req = req_valid_o;
        if (rd_valid_o === 1'b1) begin
            e16 = exp_rd.size() ? {8'h00, exp_rd.pop_front()} : 16'hffff;
            `CHK("rd_data_o", e16, {8'h00, rd_data_o})
        end
        if (req_v2 === 1'b1) begin
            e16 = exp_req2.size() ? exp_req2.pop_front() : 16'hffff;
            `CHK("req_fault_link", e16, {req_w2, req_a2, req_w2 ? req_d2 : 8'h00})
        end
        // The wire itself: the first byte of each frame and the trailing byte of reads.
        if (link1.slave_select_n === 1'b1) begin
            if (nbits > 0 && frame_rd === 1'b1) `CHK("trailing_byte", 8'h00, sh)
            nbits = 0;
        end else if (link1.sck === 1'b1 && sck_p === 1'b0) begin
            sh = {sh[6:0], link1.mosi};
            nbits++;
            if (nbits == 8) `CHK("first_byte", exp_first, sh)
        end
        sck_p = link1.sck;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_ready(input int lim);
        int t;
        t = 0;
        while (cmd_ready_o !== 1'b1 && t < lim) begin
            @(posedge ref_clk_i);
            #1;
            t++;
        end
        if (cmd_ready_o !== 1'b1) begin
            $display("mismatch cmd_ready_o expected 1 seen %b", cmd_ready_o);
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [3:0] n);
        logic [6:0] p;
        p = a;
        for (int k = 0; k < n; k++) begin
            wbuf[k] = 8'($random(seed));
            if (rd) begin
                exp_req.push_back({1'b0, 7'(a + k), 8'h00});
                exp_rd.push_back(mmem[7'(a + k)]);
            end else begin
                exp_req.push_back({1'b1, p, wbuf[k]});
                mmem[p] = wbuf[k];
                if (p != `SHP_FIFO_ADDR) p = p + 7'h01;
            end
        end
        if (rd) exp_req.push_back(16'h0000);
        frame_rd = rd;
        exp_first = {a, rd};
        wait_ready(20);
        {cmd_valid_i, cmd_read_i, cmd_addr_i, cmd_len_i} = {1'b1, rd, a, n};
        @(posedge ref_clk_i);
        #1;
        cmd_valid_i = 1'b0;
        wait_ready(3000);
        repeat (10) @(posedge ref_clk_i);
        #1;
        `CHK("requests_left", 0, exp_req.size() + exp_rd.size())
        $display("test rd=%0b addr=%h len=%0d done", rd, a, n);
    endtask
    // Bench-made link clock: 800 ns period, changes just after system clock edges, still outside frames.
    task automatic bit2(input logic b);
        #100 link2.mosi = b;
        #300 link2.sck = 1'b1;
        #400 link2.sck = 1'b0;
    endtask
    task automatic byte2(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit2(v[i]);
    endtask
    task automatic fault_frame();
        logic [6:0] a;
        logic [7:0] d;
        a = 7'($random(seed));
        d = 8'($random(seed));
        exp_req2.push_back({1'b0, a, 8'h00});
        exp_req2.push_back({1'b1, a, d});
        // A read stream cut inside its second byte: miso carries data until select rises.
        link2.slave_select_n = 1'b0;
        byte2({a, 1'b1});
        repeat (5) bit2(1'($random(seed)));
        `CHK("miso_read_bit", 1'b1, link2.miso)
        link2.slave_select_n = 1'b1;
        link2.mosi = ~link2.mosi;
        #800;
        `CHK("miso_disabled", 1'b0, link2.miso)
        link2.slave_select_n = 1'b0;
        byte2({a, 1'b0});
        byte2(d);
        #400 link2.slave_select_n = 1'b1;
        link2.mosi = ~link2.mosi;
        #2000;
        `CHK("fault_requests_left", 0, exp_req2.size())
        $display("test partial byte discard done");
    endtask
    initial begin
        {resetn_i, cmd_valid_i, cmd_read_i, cmd_addr_i, cmd_len_i, sel_lo2, sel_hi2, wake2} = '0;
        {link2.sck, link2.mosi, link2.slave_select_n} = 3'h1;
        for (int i = 0; i < 128; i++) begin
            bank[i] = 8'(i * 5 + 3);
            mmem[i] = 8'(i * 5 + 3);
        end
        repeat (2) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        `CHK("host_if_mode_o", SHP_IF_SPI, mode1)
        // The last strap setting left behind is SPI, which the faulty-link test needs.
        for (int j = 0; j < 4; j++) begin
            {sel_hi2, sel_lo2} = 2'((j + 3) % 4);
            wake2 = 1'b1;
            repeat (2) @(posedge ref_clk_i);
            #1 wake2 = 1'b0;
            repeat (8) @(posedge ref_clk_i);
            #1;
            `CHK("host_if_mode_o", exp_mode[(j + 3) % 4], mode2)
            `CHK("host_if_valid_o", 1'b1, valid2)
        end
        $display("test strap decode done");
        a0 = 7'($random(seed));
        if (a0 == `SHP_FIFO_ADDR) a0 = 7'h40;
        run_cmd(1'b0, a0, 4'hf);
        run_cmd(1'b0, `SHP_FIFO_ADDR, 4'h4);
        run_cmd(1'b1, a0, 4'hf);
        run_cmd(1'b1, 7'h03, 4'h4);
        for (int j = 0; j < 3; j++) begin
            a0 = 7'($random(seed));
            n0 = 4'(1 + {$random(seed)} % 15);
            run_cmd(1'b0, a0, n0);
            run_cmd(1'b1, a0, n0);
        end
        run_cmd(1'b1, a0, 4'h1);
        fault_frame();
        tally_and_finish();
    end
endmodule
